// ---- rtl/srcr_map.vh ----
// constants of the one-to-one channel router: register offsets, field
// positions, codes and reset values.
// assumes inclusion by bare name from the router, slot table and testbench sources.
`ifndef SRCR_MAP_VH
`define SRCR_MAP_VH
// register offsets on the plain 8-bit register port
`define SRCR_A_QSEL      8'h00
`define SRCR_A_QCFG      8'h01
`define SRCR_A_SSEL      8'h02
`define SRCR_A_SCFG      8'h03
`define SRCR_A_MODE      8'h04
`define SRCR_A_STAT      8'h05
// queue select fields: direction, number, bit order of the entry
`define SRCR_SEL_DIR     0
`define SRCR_SEL_NUM     5:1
`define SRCR_SEL_IDX     5:0
`define SRCR_SEL_REV     6
// queue config fields
`define SRCR_QC_TRP      0
`define SRCR_QC_IRQ      3:1
`define SRCR_QC_IFF      4
`define SRCR_QC_FLOW     7:5
// data-flow codes
`define SRCR_FLOW_LINE   3'h0
`define SRCR_FLOW_PCM    3'h1
`define SRCR_FLOW_XCHG   3'h6
// slot config fields and pin routing codes
`define SRCR_SC_DIR      0
`define SRCR_SC_NUM      5:1
`define SRCR_SC_ROUT     7:6
`define SRCR_ROUT_AB     2'h2
`define SRCR_ROUT_BA     2'h3
// mode field and its simple value
`define SRCR_MODE_FLD    1:0
`define SRCR_MODE_SIMPLE 2'h0
// directions
`define SRCR_DIR_TX      1'h0
`define SRCR_DIR_RX      1'h1
// fill and idle bytes
`define SRCR_FILL_FLAG   8'h7E
`define SRCR_FILL_ONES   8'hFF
// reset and zero values
`define SRCR_CFG_RST     8'h00
`define SRCR_ZERO8       8'h00
`define SRCR_ZERO6       6'h00
`define SRCR_ZERO5       5'h00
`define SRCR_ZERO4       4'h0
`define SRCR_ZERO2       2'h0
`define SRCR_IRQ_OFF     3'h0
`define SRCR_CNT_ONE     4'h1
`define SRCR_CHAN_RST    32'h00000000
`define SRCR_ENT_RST     64'h0000000000000000
// table sizes
`define SRCR_ENTRIES     64
`define SRCR_CHANS       32
`endif

// ---- rtl/srcr_bitrev.v ----
// byte bit-order switch between a queue and its internal channel.
// assumes a purely combinational use; no clock.
`timescale 1ns/1ps
`default_nettype none
module srcr_bitrev (
  input  wire       i_rev,   // 1: swap bit order
  input  wire [7:0] i_data,  // byte in
  output wire [7:0] o_data   // byte out
);
  genvar g;
  // each output bit picks its own or its mirrored input bit
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_bit
      assign o_data[g] = i_rev ? i_data[7-g] : i_data[g];
    end
  endgenerate
endmodule
`default_nettype wire

// ---- rtl/srcr_slot_table.v ----
// slot assigner table: one byte per (slot, direction), three read ports.
// assumes index = {slot number, direction}; written from the register port.
`timescale 1ns/1ps
`default_nettype none
`include "srcr_map.vh"
module srcr_slot_table (
  input  wire       i_clk,     // system clock
  input  wire       i_reset,   // async reset, active high
  input  wire       i_we,      // write strobe
  input  wire [5:0] i_widx,    // write index
  input  wire [7:0] i_wdata,   // write data
  input  wire [5:0] i_ridx_a,  // read index a
  input  wire [5:0] i_ridx_b,  // read index b
  input  wire [5:0] i_ridx_c,  // read index c
  output wire [7:0] o_rdata_a, // read data a
  output wire [7:0] o_rdata_b, // read data b
  output wire [7:0] o_rdata_c  // read data c
);
  reg [7:0] cfg_ff [0:`SRCR_ENTRIES-1]; // channel, direction, routing
  integer   k;                          // reset loop index

  // reset leaves every slot unrouted, so no pin is driven by default
  always @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      for (k = 0; k < `SRCR_ENTRIES; k = k + 1)
        cfg_ff[k] <= `SRCR_CFG_RST;
    end
    else if (i_we)
    begin
      cfg_ff[i_widx] <= i_wdata;
    end
  end

  assign o_rdata_a = cfg_ff[i_ridx_a];
  assign o_rdata_b = cfg_ff[i_ridx_b];
  assign o_rdata_c = cfg_ff[i_ridx_c];
endmodule
`default_nettype wire

// ---- rtl/srcr_router.v ----
// one-to-one channel router: ties host queues, line channels and pcm slots
// through 32 internal channels, with exchanger and pcm loops.
// assumes line, pcm and queue strobes come from logic on I_CLK.
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "srcr_map.vh"
module srcr_router #(
  parameter [5:0] LINE_CHANNELS = 6'h20  // line channels on this variant
) (
  input  wire        I_CLK,          // system clock, 40 MHz
  input  wire        I_RESET,        // async reset, active high
  input  wire        I_WR,           // register write strobe
  input  wire        I_RD,           // register read strobe
  input  wire [7:0]  I_ADDR,         // register address
  input  wire [7:0]  I_WDATA,        // register write data
  output reg  [7:0]  O_RDATA,        // read data, cycle after I_RD
  input  wire        I_LINE_STB,     // line channel byte slot
  input  wire [4:0]  I_LINE_CH,      // line channel number
  input  wire [7:0]  I_LINE_RXD,     // byte received from the line
  output reg         O_LINE_TX_STB,  // transmit byte valid
  output reg  [4:0]  O_LINE_TX_CH,   // transmit channel
  output reg  [7:0]  O_LINE_TXD,     // byte to the line
  input  wire        I_PCM_STB,      // pcm slot byte time
  input  wire [4:0]  I_PCM_SLOT,     // pcm slot number
  input  wire [7:0]  I_PCM_A_IN,     // byte seen on serial pin a
  input  wire [7:0]  I_PCM_B_IN,     // byte seen on serial pin b
  output reg  [7:0]  O_PCM_A_OUT,    // byte for serial pin a
  output reg         O_PCM_A_OE,     // pin a driven
  output reg  [7:0]  O_PCM_B_OUT,    // byte for serial pin b
  output reg         O_PCM_B_OE,     // pin b driven
  input  wire        I_FIFO_TX_STB,  // queue offers a transmit byte
  input  wire [4:0]  I_FIFO_TX_CH,   // its queue number
  input  wire [7:0]  I_FIFO_TX_DATA, // the byte
  output reg  [31:0] O_FIFO_TX_FULL, // per queue: holding byte busy
  output reg         O_FIFO_RX_STB,  // receive byte to a queue
  output reg  [4:0]  O_FIFO_RX_CH,   // its queue number
  output reg  [7:0]  O_FIFO_RX_DATA, // the byte
  output reg         O_FIFO_EVT,     // queue event pulse
  output reg  [4:0]  O_FIFO_EVT_CH,  // event queue number
  output reg         O_FIFO_EVT_EOF  // 1 end of frame, 0 periodic
);
  // register file state
  reg [7:0]  qcfg_ff [0:`SRCR_ENTRIES-1]; // per queue entry config
  reg [63:0] rev_ff;                      // per queue entry bit order
  reg [5:0]  qsel_ff;                     // selected queue entry
  reg [5:0]  ssel_ff;                     // selected slot entry
  reg [1:0]  mode_ff;                     // flow mode field
  // data path state
  reg [7:0]  hold_ff  [0:`SRCR_CHANS-1];  // transmit holding bytes
  reg [7:0]  lbuf_ff  [0:`SRCR_CHANS-1];  // last byte from each line ch
  reg [7:0]  pbuf_ff  [0:`SRCR_ENTRIES-1];// pcm switching buffer
  reg [3:0]  pcnt_ff  [0:`SRCR_CHANS-1];  // periodic event counters
  reg [31:0] inframe_ff;                  // hdlc receive inside a frame
  integer    k;                           // reset loop index

  // slot assigner lookups
  wire [7:0] tx_cfg;   // transmit slot entry of the current slot
  wire [7:0] rx_cfg;   // receive slot entry of the current slot
  wire [7:0] cpu_scfg; // entry selected for software
  wire       slot_we;  // software writes the selected slot entry

  assign slot_we = I_WR & (I_ADDR == `SRCR_A_SCFG);

  srcr_slot_table u_slots (
    .i_clk     (I_CLK),
    .i_reset   (I_RESET),
    .i_we      (slot_we),
    .i_widx    (ssel_ff),
    .i_wdata   (I_WDATA),
    .i_ridx_a  ({I_PCM_SLOT, `SRCR_DIR_TX}),
    .i_ridx_b  ({I_PCM_SLOT, `SRCR_DIR_RX}),
    .i_ridx_c  (ssel_ff),
    .o_rdata_a (tx_cfg),
    .o_rdata_b (rx_cfg),
    .o_rdata_c (cpu_scfg)
  );

  // engine runs only in the one-to-one mode; other modes are not built
  wire sm_on   = (mode_ff == `SRCR_MODE_SIMPLE);
  wire pcm_ev  = I_PCM_STB & sm_on;
  // pcm wins a shared cycle; absent line channels are left untouched
  wire line_ev = I_LINE_STB & ~I_PCM_STB & sm_on &
                 ({1'b0, I_LINE_CH} < LINE_CHANNELS);
  // queue number equals channel number, so no assigner table exists
  wire [4:0] tx_ch = pcm_ev ? tx_cfg[`SRCR_SC_NUM] : I_LINE_CH;
  wire [4:0] rx_ch = pcm_ev ? rx_cfg[`SRCR_SC_NUM] : I_LINE_CH;
  wire [1:0] rx_rout = rx_cfg[`SRCR_SC_ROUT];
  wire [1:0] tx_rout = tx_cfg[`SRCR_SC_ROUT];
  wire rx_act = (rx_rout == `SRCR_ROUT_AB) | (rx_rout == `SRCR_ROUT_BA);
  // receive byte: routing 10 reads pin b, 11 reads pin a
  wire [7:0] rx_raw = !pcm_ev ? I_LINE_RXD :
                      (rx_rout == `SRCR_ROUT_AB) ? I_PCM_B_IN :
                      I_PCM_A_IN;
  wire [7:0] tq = qcfg_ff[{tx_ch, `SRCR_DIR_TX}];  // transmit queue cfg
  wire [7:0] rq = qcfg_ff[{rx_ch, `SRCR_DIR_RX}];  // receive queue cfg
  // a queue runs when transparent or with a nonzero trigger field
  wire tq_en = tq[`SRCR_QC_TRP] | (tq[`SRCR_QC_IRQ] != `SRCR_IRQ_OFF);
  wire rq_en = rq[`SRCR_QC_TRP] | (rq[`SRCR_QC_IRQ] != `SRCR_IRQ_OFF);
  wire [7:0] tx_rev;  // holding byte in line bit order
  wire [7:0] rx_rev;  // received byte in queue bit order

  srcr_bitrev u_txrev (
    .i_rev  (rev_ff[{tx_ch, `SRCR_DIR_TX}]),
    .i_data (hold_ff[tx_ch]),
    .o_data (tx_rev)
  );

  srcr_bitrev u_rxrev (
    .i_rev  (rev_ff[{rx_ch, `SRCR_DIR_RX}]),
    .i_data (rx_raw),
    .o_data (rx_rev)
  );

  // engine decisions for the current slot or line byte
  reg [7:0] t_byte;    // byte sent this cycle
  reg       t_fifo;    // byte comes from the transmit queue
  reg       t_take;    // holding byte consumed
  reg       r_ok;      // receive byte belongs to an enabled queue
  reg       r_hdlc;    // receive queue filters frames
  reg       r_give;    // byte delivered to the queue
  reg       r_eof;     // end of frame event
  reg       r_per;     // periodic event
  reg       r_set;     // frame started
  reg       r_clr;     // frame ended
  reg       r_inc;     // periodic counter steps
  reg       r_rst;     // periodic counter restarts
  reg [3:0] r_thr;     // periodic threshold
  always @*
  begin
    t_byte = `SRCR_FILL_ONES;
    t_fifo = 1'b0;
    t_take = 1'b0;
    r_give = 1'b0;
    r_eof  = 1'b0;
    r_per  = 1'b0;
    r_set  = 1'b0;
    r_clr  = 1'b0;
    r_inc  = 1'b0;
    r_rst  = 1'b0;
    r_thr  = {rq[`SRCR_QC_IRQ], 1'b1};
    // transmit source; pcm goes by the transmit slot entry, the line exchanger by the receive queue entry
    if (pcm_ev)
    begin
      if (tx_cfg[`SRCR_SC_DIR] == `SRCR_DIR_RX)
        t_byte = pbuf_ff[{tx_ch, `SRCR_DIR_RX}];
      else if (tq[`SRCR_QC_FLOW] == `SRCR_FLOW_XCHG)
        t_byte = lbuf_ff[tx_ch];
      else if (tq_en)
        t_fifo = 1'b1;
      else
        t_byte = pbuf_ff[{tx_ch, `SRCR_DIR_TX}];
    end
    else if (line_ev)
    begin
      // exchanger: the receive queue entry steers pcm onto the line
      if (rq[`SRCR_QC_FLOW] == `SRCR_FLOW_XCHG)
        t_byte = pbuf_ff[{tx_ch, `SRCR_DIR_RX}];
      else if (tq_en)
        t_fifo = 1'b1;
    end
    // queue transmit: holding byte, else fill in hdlc, else idle ones
    if (t_fifo)
    begin
      if (O_FIFO_TX_FULL[tx_ch])
      begin
        t_byte = tx_rev;
        t_take = 1'b1;
      end
      else if (!tq[`SRCR_QC_TRP])
        t_byte = tq[`SRCR_QC_IFF] ? `SRCR_FILL_ONES :
                 `SRCR_FILL_FLAG;
    end
    // receive side: pcm feeds code 001 queues, line feeds the others
    if (pcm_ev)
      r_ok = rx_act & (rx_cfg[`SRCR_SC_DIR] == `SRCR_DIR_RX) &
             (rq[`SRCR_QC_FLOW] == `SRCR_FLOW_PCM) & rq_en;
    else
      r_ok = line_ev & (rq[`SRCR_QC_FLOW] != `SRCR_FLOW_PCM) &
             rq_en;
    // the exchanger ignores the hdlc setting
    r_hdlc = ~rq[`SRCR_QC_TRP] &
             (rq[`SRCR_QC_FLOW] != `SRCR_FLOW_XCHG);
    if (r_ok)
    begin
      if (r_hdlc)
      begin
        // flag bytes are dropped; one after data closes the frame
        if (rx_raw == `SRCR_FILL_FLAG)
        begin
          r_eof = inframe_ff[rx_ch];
          r_clr = 1'b1;
        end
        else
        begin
          r_give = 1'b1;
          r_set  = 1'b1;
        end
      end
      else
      begin
        r_give = 1'b1;
        if (rq[`SRCR_QC_IRQ] != `SRCR_IRQ_OFF)
        begin
          if (pcnt_ff[rx_ch] == r_thr)
          begin
            r_per = 1'b1;
            r_rst = 1'b1;
          end
          else
            r_inc = 1'b1;
        end
      end
    end
  end

  // register file, buffers and registered outputs
  always @(posedge I_CLK or posedge I_RESET)
  begin
    if (I_RESET)
    begin
      for (k = 0; k < `SRCR_ENTRIES; k = k + 1)
      begin
        qcfg_ff[k] <= `SRCR_CFG_RST;
        pbuf_ff[k] <= `SRCR_FILL_ONES;  // idle byte, never unknown
      end
      for (k = 0; k < `SRCR_CHANS; k = k + 1)
      begin
        pcnt_ff[k] <= `SRCR_ZERO4;
        lbuf_ff[k] <= `SRCR_FILL_ONES;
        hold_ff[k] <= `SRCR_FILL_ONES;
      end
      rev_ff         <= `SRCR_ENT_RST;
      qsel_ff        <= `SRCR_ZERO6;
      ssel_ff        <= `SRCR_ZERO6;
      mode_ff        <= `SRCR_MODE_SIMPLE;
      inframe_ff     <= `SRCR_CHAN_RST;
      O_RDATA        <= `SRCR_ZERO8;
      O_LINE_TX_STB  <= 1'b0;
      O_LINE_TX_CH   <= `SRCR_ZERO5;
      O_LINE_TXD     <= `SRCR_FILL_ONES;
      O_PCM_A_OUT    <= `SRCR_FILL_ONES;
      O_PCM_A_OE     <= 1'b0;
      O_PCM_B_OUT    <= `SRCR_FILL_ONES;
      O_PCM_B_OE     <= 1'b0;
      O_FIFO_TX_FULL <= `SRCR_CHAN_RST;
      O_FIFO_RX_STB  <= 1'b0;
      O_FIFO_RX_CH   <= `SRCR_ZERO5;
      O_FIFO_RX_DATA <= `SRCR_ZERO8;
      O_FIFO_EVT     <= 1'b0;
      O_FIFO_EVT_CH  <= `SRCR_ZERO5;
      O_FIFO_EVT_EOF <= 1'b0;
    end
    else
    begin
      // software writes; the bit order rides with the queue select
      if (I_WR)
      begin
        case (I_ADDR)
          `SRCR_A_QSEL:
          begin
            qsel_ff <= I_WDATA[`SRCR_SEL_IDX];
            rev_ff[I_WDATA[`SRCR_SEL_IDX]] <= I_WDATA[`SRCR_SEL_REV];
          end
          `SRCR_A_QCFG: qcfg_ff[qsel_ff] <= I_WDATA;
          `SRCR_A_SSEL: ssel_ff <= I_WDATA[`SRCR_SEL_IDX];
          `SRCR_A_MODE: mode_ff <= I_WDATA[`SRCR_MODE_FLD];
          default: ;  // unmapped writes are ignored
        endcase
      end
      // read data stands for one cycle only, zero otherwise
      O_RDATA <= `SRCR_ZERO8;
      if (I_RD)
      begin
        case (I_ADDR)
          `SRCR_A_QSEL: O_RDATA <= {1'b0, rev_ff[qsel_ff], qsel_ff};
          `SRCR_A_QCFG: O_RDATA <= qcfg_ff[qsel_ff];
          `SRCR_A_SSEL: O_RDATA <= {`SRCR_ZERO2, ssel_ff};
          `SRCR_A_SCFG: O_RDATA <= cpu_scfg;
          `SRCR_A_MODE: O_RDATA <= {`SRCR_ZERO6, mode_ff};
          `SRCR_A_STAT: O_RDATA <= {`SRCR_ZERO5,
                          inframe_ff[qsel_ff[`SRCR_SEL_NUM]],
                          O_FIFO_TX_FULL[qsel_ff[`SRCR_SEL_NUM]], sm_on};
          default: O_RDATA <= `SRCR_ZERO8;
        endcase
      end
      // holding byte: a write while busy is dropped, the port shows busy
      // consumption clears on its own, so an offer to another queue in
      // the same cycle cannot leave a sent byte marked busy
      if (t_take)
        O_FIFO_TX_FULL[tx_ch] <= 1'b0;
      if (I_FIFO_TX_STB && !O_FIFO_TX_FULL[I_FIFO_TX_CH])
      begin
        hold_ff[I_FIFO_TX_CH]        <= I_FIFO_TX_DATA;
        O_FIFO_TX_FULL[I_FIFO_TX_CH] <= 1'b1;
      end
      // line output only while a line byte is handled
      O_LINE_TX_STB <= line_ev;
      if (line_ev)
      begin
        O_LINE_TX_CH   <= I_LINE_CH;
        O_LINE_TXD     <= t_byte;
        lbuf_ff[I_LINE_CH] <= I_LINE_RXD;
      end
      // pcm pins hold their drive until the next slot time
      if (pcm_ev)
      begin
        O_PCM_A_OE  <= (tx_rout == `SRCR_ROUT_AB);
        O_PCM_B_OE  <= (tx_rout == `SRCR_ROUT_BA);
        O_PCM_A_OUT <= t_byte;
        O_PCM_B_OUT <= t_byte;
        if (rx_act)
          pbuf_ff[{rx_ch, rx_cfg[`SRCR_SC_DIR]}] <= rx_raw;
      end
      // receive delivery and events
      O_FIFO_RX_STB <= r_give;
      if (r_give)
      begin
        O_FIFO_RX_CH   <= rx_ch;
        O_FIFO_RX_DATA <= rx_rev;
      end
      O_FIFO_EVT <= r_eof | r_per;
      if (r_eof | r_per)
      begin
        O_FIFO_EVT_CH  <= rx_ch;
        O_FIFO_EVT_EOF <= r_eof;
      end
      if (r_set)
        inframe_ff[rx_ch] <= 1'b1;
      else if (r_clr)
        inframe_ff[rx_ch] <= 1'b0;
      if (r_rst)
        pcnt_ff[rx_ch] <= `SRCR_ZERO4;
      else if (r_inc)
        pcnt_ff[rx_ch] <= pcnt_ff[rx_ch] + `SRCR_CNT_ONE;
    end
  end
endmodule
`default_nettype wire

// ---- dv/srcr_router_chk.sv ----
// checker: port timing relations of the one-to-one channel router
// assumes a bind onto srcr_router; one clock domain, async reset
`timescale 1ns/1ps
`default_nettype none
module srcr_router_chk #(
  parameter [5:0] LINE_CHANNELS = 6'h20  // line channels present
) (
  input wire logic        I_CLK,          // system clock
  input wire logic        I_RESET,        // async reset, high
  input wire logic        I_RD,           // read strobe
  input wire logic [7:0]  O_RDATA,        // read data
  input wire logic        I_LINE_STB,     // line byte time
  input wire logic [4:0]  I_LINE_CH,      // line channel
  input wire logic        I_PCM_STB,      // pcm slot time
  input wire logic        O_LINE_TX_STB,  // line byte valid
  input wire logic [4:0]  O_LINE_TX_CH,   // line tx channel
  input wire logic [7:0]  O_PCM_A_OUT,    // pin a byte
  input wire logic        O_PCM_A_OE,     // pin a driven
  input wire logic [7:0]  O_PCM_B_OUT,    // pin b byte
  input wire logic        O_PCM_B_OE,     // pin b driven
  input wire logic        I_FIFO_TX_STB,  // queue offer
  input wire logic [4:0]  I_FIFO_TX_CH,   // offering queue
  input wire logic [31:0] O_FIFO_TX_FULL, // holding busy
  input wire logic        O_FIFO_RX_STB,  // rx byte valid
  input wire logic [4:0]  O_FIFO_RX_CH,   // rx queue
  input wire logic        O_FIFO_EVT      // queue event
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  // read data must not linger, or software sees stale bytes
  AST_RD_IDLE: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("read data outside its cycle");
  AST_LINE_ECHO: assert property (
    O_LINE_TX_STB |-> $past(I_LINE_STB && !I_PCM_STB)
    && O_LINE_TX_CH == $past(I_LINE_CH)) else $error("line tx without cause");
  AST_LINE_ABSENT: assert property (
    I_LINE_STB && ({1'b0, I_LINE_CH} >= LINE_CHANNELS) |=> !O_LINE_TX_STB)
    else $error("absent line channel answered");
  AST_OE_EXCL: assert property (
    !(O_PCM_A_OE && O_PCM_B_OE)) else $error("both serial pins driven");
  AST_PCM_HOLD: assert property (
    !$past(I_PCM_STB) |-> $stable(O_PCM_A_OUT) && $stable(O_PCM_B_OUT)
    && $stable(O_PCM_A_OE) && $stable(O_PCM_B_OE))
    else $error("pin outputs moved between slots");
  AST_RX_CH: assert property (
    O_FIFO_RX_STB && $past(I_LINE_STB && !I_PCM_STB)
    |-> O_FIFO_RX_CH == $past(I_LINE_CH)) else $error("rx queue mismatch");
  AST_EVT_CAUSE: assert property (
    O_FIFO_EVT |-> $past(I_LINE_STB || I_PCM_STB))
    else $error("queue event without byte time");
  AST_FULL_SET: assert property (
    I_FIFO_TX_STB && !O_FIFO_TX_FULL[I_FIFO_TX_CH]
    |=> O_FIFO_TX_FULL[$past(I_FIFO_TX_CH)]) else $error("offer not held");
  // main traffic kinds reached
  cover property (I_LINE_STB ##1 O_LINE_TX_STB);
  cover property (I_PCM_STB ##1 O_PCM_A_OE);
  cover property (O_FIFO_EVT);
endmodule
`default_nettype wire

// ---- dv/srcr_far_model.sv ----
// far side: line interfaces and pcm bus devices feeding the router
// assumes tasks are called from the bench; one byte time per call
`timescale 1ns/1ps
`default_nettype none
module srcr_far_model (
  input  wire logic       i_clk,      // system clock
  output var  logic       o_line_stb, // line byte time
  output var  logic [4:0] o_line_ch,  // line channel
  output var  logic [7:0] o_line_rxd, // byte from the line
  output var  logic       o_pcm_stb,  // pcm slot time
  output var  logic [4:0] o_pcm_slot, // slot number
  output var  logic [7:0] o_pcm_a,    // byte on pin a
  output var  logic [7:0] o_pcm_b     // byte on pin b
);
  // quiet bus at time zero
  initial
  begin
    o_line_stb = 1'b0;
    o_line_ch  = 5'h00;
    o_line_rxd = 8'hA5;
    o_pcm_stb  = 1'b0;
    o_pcm_slot = 5'h00;
    o_pcm_a    = 8'hA5;
    o_pcm_b    = 8'h5A;
  end
  // one line byte; the data then shows its inverse so a stale byte can
  // never pass for a fresh one
  task automatic send_line(input logic [4:0] ch, input logic [7:0] d);
    @(posedge i_clk);
    o_line_stb <= 1'b1;
    o_line_ch  <= ch;
    o_line_rxd <= d;
    @(posedge i_clk);
    o_line_stb <= 1'b0;
    o_line_rxd <= ~d;
    #1;
  endtask
  // one slot time; released pins likewise turn to the inverse
  task automatic send_slot(input logic [4:0] s, input logic [7:0] a,
                           input logic [7:0] b);
    @(posedge i_clk);
    o_pcm_stb  <= 1'b1;
    o_pcm_slot <= s;
    o_pcm_a    <= a;
    o_pcm_b    <= b;
    @(posedge i_clk);
    o_pcm_stb  <= 1'b0;
    o_pcm_a    <= ~a;
    o_pcm_b    <= ~b;
    #1;
  endtask
endmodule
`default_nettype wire

// ---- dv/srcr_router_test.sv ----
// testbench: registers set up over the plain port, then traffic per link
// assumes the far model drives line and pcm inputs; 25 ns clock
`timescale 1ns/1ps
`default_nettype none
`include "srcr_map.vh"
module srcr_router_test;
  localparam [5:0] LINE_CHANNELS = 6'h10;  // four-interface variant
  logic        clk, reset, wr_s, rd_s;     // clock, reset, strobes
  logic [7:0]  addr, wdata, rdata;         // register port
  logic        l_stb, p_stb, ltx_stb;      // byte times
  logic [4:0]  l_ch, p_slot, ltx_ch;       // channel and slot
  logic [7:0]  l_rxd, p_a, p_b, ltxd;      // line and pin bytes
  logic [7:0]  a_out, b_out;               // pin outputs
  logic        a_oe, b_oe;                 // pin enables
  logic        f_stb, rx_stb, evt, eof;    // queue strobes
  logic [4:0]  f_ch, rx_ch, evt_ch;        // queue numbers
  logic [7:0]  f_d, rx_d;                  // queue bytes
  logic [31:0] full;                       // holding busy
  int          fail_count = 0;             // mismatches
  int          checks = 0;                 // comparisons
  int          i;                          // loop index

  srcr_router #(.LINE_CHANNELS(LINE_CHANNELS)) i_srcr_router (
    .I_CLK(clk), .I_RESET(reset), .I_WR(wr_s), .I_RD(rd_s),
    .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata),
    .I_LINE_STB(l_stb), .I_LINE_CH(l_ch), .I_LINE_RXD(l_rxd),
    .O_LINE_TX_STB(ltx_stb), .O_LINE_TX_CH(ltx_ch), .O_LINE_TXD(ltxd),
    .I_PCM_STB(p_stb), .I_PCM_SLOT(p_slot), .I_PCM_A_IN(p_a),
    .I_PCM_B_IN(p_b), .O_PCM_A_OUT(a_out), .O_PCM_A_OE(a_oe),
    .O_PCM_B_OUT(b_out), .O_PCM_B_OE(b_oe), .I_FIFO_TX_STB(f_stb),
    .I_FIFO_TX_CH(f_ch), .I_FIFO_TX_DATA(f_d), .O_FIFO_TX_FULL(full),
    .O_FIFO_RX_STB(rx_stb), .O_FIFO_RX_CH(rx_ch), .O_FIFO_RX_DATA(rx_d),
    .O_FIFO_EVT(evt), .O_FIFO_EVT_CH(evt_ch), .O_FIFO_EVT_EOF(eof));
  srcr_far_model i_srcr_far_model (
    .i_clk(clk), .o_line_stb(l_stb), .o_line_ch(l_ch), .o_line_rxd(l_rxd),
    .o_pcm_stb(p_stb), .o_pcm_slot(p_slot), .o_pcm_a(p_a), .o_pcm_b(p_b));

  // 40 MHz clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // compare, count, report
  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask
  // line byte answered on channel c with byte d
  task automatic chk_ln(input string w, input logic [4:0] c,
                        input logic [7:0] d);
    chk(w, {1'b1, c, d}, {ltx_stb, ltx_ch, ltxd});
  endtask
  // one-cycle write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s  <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask
  // one-cycle read; data is valid only in the following cycle
  task automatic rd_chk(input string w, input logic [7:0] a,
                        input logic [7:0] e);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(w, e, rdata);
  endtask
  // select a queue or slot entry, then write its config
  task automatic cfg(input logic [7:0] sa, input logic [7:0] s,
                     input logic [7:0] d);
    wr(sa, s);
    wr(sa + 8'h01, d);
  endtask
  // queue offers one transmit byte; busy must rise
  task automatic offer(input logic [4:0] ch, input logic [7:0] d);
    @(posedge clk);
    f_stb <= 1'b1;
    f_ch  <= ch;
    f_d   <= d;
    @(posedge clk);
    f_stb <= 1'b0;
    #1;
    chk("holding busy", 1'b1, full[ch]);
  endtask
  // verdict and end of run
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // a hang is cut short here
  initial
  begin
    repeat (6000) @(posedge clk);
    fail_count++;
    $display("mismatch run expected done seen timeout");
    give_verdict;
  end

  initial
  begin
    reset = 1'b1;
    wr_s  = 1'b0;
    rd_s  = 1'b0;
    addr  = 8'h00;
    wdata = 8'h00;
    f_stb = 1'b0;
    f_ch  = 5'h00;
    f_d   = 8'h00;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    // reset state, unmapped read, simple mode
    rd_chk("status", `SRCR_A_STAT, 8'h01);
    rd_chk("unmapped", 8'h3C, 8'h00);
    wr(`SRCR_A_MODE, {6'h00, `SRCR_MODE_SIMPLE});
    $display("test reset done");
    // queue 9 to line: hdlc, fill, data, reversed, disabled neighbour
    cfg(`SRCR_A_QSEL, 8'h12, 8'h02);
    rd_chk("queue config", `SRCR_A_QCFG, 8'h02);
    i_srcr_far_model.send_line(5'h09, 8'h00);
    chk_ln("fill", 5'h09, `SRCR_FILL_FLAG);
    offer(5'h09, 8'h01);
    i_srcr_far_model.send_line(5'h09, 8'h00);
    chk_ln("normal order", 5'h09, 8'h01);
    cfg(`SRCR_A_QSEL, 8'h52, 8'h02);
    offer(5'h09, 8'h01);
    i_srcr_far_model.send_line(5'h09, 8'h00);
    chk_ln("reversed", 5'h09, 8'h80);
    i_srcr_far_model.send_line(5'h0A, 8'h00);
    chk_ln("not enabled", 5'h0A, 8'hFF);
    cfg(`SRCR_A_QSEL, 8'h13, 8'h02);
    i_srcr_far_model.send_line(5'h09, 8'h11);
    chk("rx byte", {1'b1, 5'h09, 8'h11}, {rx_stb, rx_ch, rx_d});
    i_srcr_far_model.send_line(5'h09, 8'h7E);
    chk("end of frame", {3'h6, 5'h09}, {evt, eof, rx_stb, evt_ch});
    $display("test queue to line done");
    // queue 17 to slot 23, pins a out and b in; periodic event every 4
    cfg(`SRCR_A_QSEL, 8'h22, 8'h21);
    cfg(`SRCR_A_QSEL, 8'h23, 8'h23);
    cfg(`SRCR_A_SSEL, 8'h2E, 8'hA2);
    cfg(`SRCR_A_SSEL, 8'h2F, 8'hA3);
    offer(5'h11, 8'h5A);
    for (i = 8'h3D; i <= 8'h40; i++)
    begin
      i_srcr_far_model.send_slot(5'h17, 8'h00, i[7:0]);
      chk("pcm rx", {1'b1, 5'h11, i[7:0]}, {rx_stb, rx_ch, rx_d});
      chk("periodic", {i == 8'h40, 1'b0}, {evt, evt & eof});
      if (i == 8'h3D)
        chk("pcm tx", {8'h5A, 2'h2}, {a_out, a_oe, b_oe});
    end
    i_srcr_far_model.send_line(5'h11, 8'h00);
    chk("absent line", 1'b0, ltx_stb);
    $display("test queue to pcm done");
    // exchanger on channel 12, slot 22; hdlc setting must not matter
    cfg(`SRCR_A_QSEL, 8'h18, 8'hC2);
    cfg(`SRCR_A_QSEL, 8'h19, 8'hC2);
    cfg(`SRCR_A_SSEL, 8'h2C, 8'h98);
    cfg(`SRCR_A_SSEL, 8'h2D, 8'h99);
    i_srcr_far_model.send_line(5'h0C, 8'h7E);
    i_srcr_far_model.send_slot(5'h16, 8'h00, 8'hC5);
    chk("line to pcm", {8'h7E, 1'b1}, {a_out, a_oe});
    i_srcr_far_model.send_line(5'h0C, 8'h00);
    chk_ln("pcm to line", 5'h0C, 8'hC5);
    $display("test exchanger done");
    // pcm loop through channel 31, one direction only, routing 11
    cfg(`SRCR_A_SSEL, 8'h09, 8'hFF);
    cfg(`SRCR_A_SSEL, 8'h0A, 8'hFF);
    i_srcr_far_model.send_slot(5'h04, 8'h96, 8'h00);
    chk("slot 4 idle", 2'h0, {a_oe, b_oe});
    i_srcr_far_model.send_slot(5'h05, 8'h00, 8'h00);
    chk("pcm loop", {8'h96, 2'h1}, {b_out, a_oe, b_oe});
    $display("test pcm loop done");
    give_verdict;
  end
endmodule

bind srcr_router srcr_router_chk #(.LINE_CHANNELS(LINE_CHANNELS))
  i_srcr_router_chk (
  .I_CLK(I_CLK), .I_RESET(I_RESET), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .I_LINE_STB(I_LINE_STB), .I_LINE_CH(I_LINE_CH), .I_PCM_STB(I_PCM_STB),
  .O_LINE_TX_STB(O_LINE_TX_STB), .O_LINE_TX_CH(O_LINE_TX_CH),
  .O_PCM_A_OUT(O_PCM_A_OUT), .O_PCM_A_OE(O_PCM_A_OE),
  .O_PCM_B_OUT(O_PCM_B_OUT), .O_PCM_B_OE(O_PCM_B_OE),
  .I_FIFO_TX_STB(I_FIFO_TX_STB), .I_FIFO_TX_CH(I_FIFO_TX_CH),
  .O_FIFO_TX_FULL(O_FIFO_TX_FULL), .O_FIFO_RX_STB(O_FIFO_RX_STB),
  .O_FIFO_RX_CH(O_FIFO_RX_CH), .O_FIFO_EVT(O_FIFO_EVT));
`default_nettype wire
